// ===== rtl/sync_ctrl_pkg.sv
/*
 * Shared constants of the multi-device sync control block: register
 * offsets, field positions and reset values.
 * Assumes a byte-addressed register port with 32-bit words.
 */
package sync_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PTR_W = 3;
   localparam int FB_W = 8;
   localparam int DIV_W = 4;
   localparam int STAT_W = 7;

   // register offsets
   localparam logic [7:0] OFS_CONTROL_WORD_ZERO = 8'h00;
   localparam logic [7:0] OFS_ALARM_STATUS_WORD = 8'h04;
   localparam logic [7:0] OFS_ALARM_MASK_WORD = 8'h08;
   localparam logic [7:0] OFS_MULTIPLIER_CONTROL_WORD = 8'h0c;
   localparam logic [7:0] OFS_SYNC_SELECT_WORD = 8'h10;
   localparam logic [7:0] OFS_POINTER_STATE_WORD = 8'h14;

   // control_word_zero fields
   localparam int CW0_DIV_SYNC_EN = 0;
   localparam int CW0_DUAL_MODE = 1;
   localparam int CW0_OFFSET_LSB = 4;
   localparam logic CW0_DIV_SYNC_EN_RST = 1'b1;
   localparam logic CW0_DUAL_MODE_RST = 1'b0;
   localparam logic [2:0] CW0_OFFSET_RST = 3'h4;

   // multiplier_control_word fields
   localparam int MCW_MULT_EN = 0;
   localparam int MCW_LOOP_SYNC_EN = 1;
   localparam int MCW_FB_RATIO_LSB = 8;
   localparam logic [7:0] MCW_FB_RATIO_RST = 8'h04;

   // sync_select_word fields
   localparam int SSW_DIV_SRC_LSB = 0;
   localparam int SSW_SINGLE_SRC = 4;
   localparam logic [1:0] DIV_SRC_OUTPUT_STROBE = 2'h0;
   localparam logic [1:0] DIV_SRC_INPUT_STROBE = 2'h1;
   localparam logic [1:0] DIV_SRC_SYNC = 2'h2;

   // alarm_status_word bit positions
   localparam int ST_COLLISION = 0;
   localparam int ST_ONE_AWAY = 1;
   localparam int ST_TWO_AWAY = 2;
   localparam int ST_WRITE_RESET = 3;
   localparam int ST_READ_RESET = 4;
   localparam int ST_LOOP_RESET = 5;
   localparam int ST_DIV_RESET = 6;

   // clock divider ratio of the internal divided clock
   localparam logic [3:0] DIV_RATIO = 4'h8;
   // stages of the single-mode read pointer handoff
   localparam int HANDOFF_STAGES = 2;
endpackage

// ===== rtl/sync_edge_detect.sv
/*
 * Three-flop synchroniser with rising-edge detection for one pin.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module sync_edge_detect (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // pin and result
   input wire logic pinIn,
   output logic levelOut,
   output logic risePulse
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once the second and third stage agree
   always_ff @(posedge core_clk) begin
      if (reset) begin
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         rise_q <= s2_q & s3_q & ~level_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign levelOut = level_q;
   assign risePulse = rise_q;
endmodule

// ===== rtl/multi_device_sync_control.sv
/*
 * Multi-device sync control: FIFO pointer resets, clock divider sync,
 * feedback divider sync with internal output strobe, alarms and registers.
 * Assumes core_clk is the conversion clock; strobe and sync pins are
 * asynchronous; writeTick and readTick come from logic on core_clk.
 */
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
module multi_device_sync_control (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [sync_ctrl_pkg::ADDR_W-1:0] regAddr,
   input wire logic [sync_ctrl_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [sync_ctrl_pkg::DATA_W-1:0] regRdData,
   // sync pins
   input wire logic outputStrobe,
   input wire logic inputStrobe,
   input wire logic syncIn,
   // fifo pointer advance
   input wire logic writeTick,
   input wire logic readTick,
   // results
   output logic writePtrReset,
   output logic readPtrReset,
   output logic dividerReset,
   output logic loopDividerReset,
   output logic internalStrobe,
   output logic dividedClkEn,
   output logic [sync_ctrl_pkg::PTR_W-1:0] writePtr,
   output logic [sync_ctrl_pkg::PTR_W-1:0] readPtr,
   output logic alarmPin,
   output logic irq
);
   logic [2:0] pinVec;
   logic [2:0] riseVec;
   logic ostrEv;
   logic istrEv;
   logic syncEv;
   // registers
   logic divSyncEn_q;
   logic dualMode_q;
   logic [2:0] fifoOffset_q;
   logic multEn_q;
   logic loopSyncEn_q;
   logic [sync_ctrl_pkg::FB_W-1:0] fbRatio_q;
   logic [1:0] divSrc_q;
   logic singleSrcSync_q;
   logic [sync_ctrl_pkg::STAT_W-1:0] status_q;
   logic [sync_ctrl_pkg::STAT_W-1:0] status_d;
   logic [sync_ctrl_pkg::STAT_W-1:0] mask_q;
   logic [sync_ctrl_pkg::DATA_W-1:0] rdData_q;
   // datapath state
   logic [sync_ctrl_pkg::FB_W-1:0] fbCnt_q;
   logic intStrobe_q;
   logic [sync_ctrl_pkg::DIV_W-1:0] divCnt_q;
   logic divEn_q;
   logic [sync_ctrl_pkg::HANDOFF_STAGES-1:0] handoff_q;
   logic [sync_ctrl_pkg::PTR_W-1:0] wrPtr_q;
   logic [sync_ctrl_pkg::PTR_W-1:0] rdPtr_q;
   logic wrReset_q;
   logic rdReset_q;
   logic divReset_q;
   logic loopReset_q;
   logic running_q;
   logic alarmPin_q;
   logic irq_q;
   // events
   logic readSource;
   logic wrEvent;
   logic rdEvent;
   logic divSrcEv;
   logic divEvent;
   logic loopEvent;
   logic fbWrap;
   logic [sync_ctrl_pkg::PTR_W-1:0] ptrDiff;
   logic [2:0] alarmNow;

   assign pinVec = {syncIn, inputStrobe, outputStrobe};

   // one synchroniser per pin
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         sync_edge_detect u_sync (
            .core_clk(core_clk),
            .reset(reset),
            .pinIn(pinVec[gi]),
            .levelOut(),
            .risePulse(riseVec[gi])
         );
      end
   endgenerate

   assign ostrEv = riseVec[0];
   assign istrEv = riseVec[1];
   assign syncEv = riseVec[2];

   // event routing
   assign readSource = multEn_q ? intStrobe_q : ostrEv;
   assign wrEvent = dualMode_q ? istrEv : (singleSrcSync_q ? syncEv : istrEv);
   assign rdEvent = dualMode_q ? readSource : handoff_q[1];
   assign loopEvent = multEn_q & loopSyncEn_q & syncEv;
   assign fbWrap = (fbCnt_q >= fbRatio_q - 8'h01);

   always_comb begin
      case (divSrc_q)
         sync_ctrl_pkg::DIV_SRC_OUTPUT_STROBE: divSrcEv = readSource;
         sync_ctrl_pkg::DIV_SRC_INPUT_STROBE: divSrcEv = istrEv;
         sync_ctrl_pkg::DIV_SRC_SYNC: divSrcEv = syncEv;
         default: divSrcEv = 1'b0;
      endcase
   end
   assign divEvent = divSyncEn_q & divSrcEv;

   // feedback divider and internal output strobe
   always_ff @(posedge core_clk) begin
      if (reset) begin
         fbCnt_q <= 8'h00;
         intStrobe_q <= 1'b0;
         loopReset_q <= 1'b0;
      end else begin
         loopReset_q <= loopEvent;
         if (loopEvent) begin
            fbCnt_q <= 8'h00;
            intStrobe_q <= 1'b0;
         end else begin
            fbCnt_q <= fbWrap ? 8'h00 : fbCnt_q + 8'h01;
            intStrobe_q <= multEn_q & fbWrap;
         end
      end
   end

   // clock divider
   always_ff @(posedge core_clk) begin
      if (reset) begin
         divCnt_q <= 4'h0;
         divEn_q <= 1'b0;
         divReset_q <= 1'b0;
      end else begin
         divReset_q <= divEvent;
         if (divEvent || divCnt_q == sync_ctrl_pkg::DIV_RATIO - 4'h1) begin
            divCnt_q <= 4'h0;
         end else begin
            divCnt_q <= divCnt_q + 4'h1;
         end
         divEn_q <= ~divEvent & (divCnt_q == sync_ctrl_pkg::DIV_RATIO - 4'h1);
      end
   end

   // single mode handoff of the write reset into the read side
   always_ff @(posedge core_clk) begin
      if (reset) begin
         handoff_q <= '0;
      end else begin
         handoff_q <= {handoff_q[0], wrEvent & ~dualMode_q};
      end
   end

   // fifo pointers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPtr_q <= 3'h0;
         rdPtr_q <= 3'h0;
         wrReset_q <= 1'b0;
         rdReset_q <= 1'b0;
         running_q <= 1'b0;
      end else begin
         wrReset_q <= wrEvent;
         rdReset_q <= rdEvent;
         if (wrEvent) begin
            wrPtr_q <= fifoOffset_q;
         end else if (writeTick) begin
            wrPtr_q <= wrPtr_q + 3'h1;
         end
         if (rdEvent) begin
            rdPtr_q <= 3'h0;
            running_q <= 1'b1;
         end else if (readTick) begin
            rdPtr_q <= rdPtr_q + 3'h1;
         end
      end
   end

   // pointer alarms
   assign ptrDiff = wrPtr_q - rdPtr_q;
   assign alarmNow[0] = running_q & (ptrDiff == 3'h0);
   assign alarmNow[1] = running_q & (ptrDiff == 3'h1 || ptrDiff == 3'h7);
   assign alarmNow[2] = running_q & (ptrDiff == 3'h2 || ptrDiff == 3'h6);

   // sticky status, set wins over read clear
   always_comb begin
      status_d = status_q;
      if (regRead && regAddr == sync_ctrl_pkg::OFS_ALARM_STATUS_WORD) begin
         status_d = '0;
      end
      status_d[2:0] = status_d[2:0] | alarmNow;
      status_d[sync_ctrl_pkg::ST_WRITE_RESET] = status_d[3] | wrEvent;
      status_d[sync_ctrl_pkg::ST_READ_RESET] = status_d[4] | rdEvent;
      status_d[sync_ctrl_pkg::ST_LOOP_RESET] = status_d[5] | loopEvent;
      status_d[sync_ctrl_pkg::ST_DIV_RESET] = status_d[6] | divEvent;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         status_q <= '0;
         alarmPin_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         alarmPin_q <= |alarmNow;
         irq_q <= |(status_d & mask_q);
      end
   end

   // register writes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         divSyncEn_q <= sync_ctrl_pkg::CW0_DIV_SYNC_EN_RST;
         dualMode_q <= sync_ctrl_pkg::CW0_DUAL_MODE_RST;
         fifoOffset_q <= sync_ctrl_pkg::CW0_OFFSET_RST;
         multEn_q <= 1'b0;
         loopSyncEn_q <= 1'b0;
         fbRatio_q <= sync_ctrl_pkg::MCW_FB_RATIO_RST;
         divSrc_q <= sync_ctrl_pkg::DIV_SRC_OUTPUT_STROBE;
         singleSrcSync_q <= 1'b0;
         mask_q <= '0;
      end else if (regWrite) begin
         case (regAddr)
            sync_ctrl_pkg::OFS_CONTROL_WORD_ZERO: begin
               divSyncEn_q <= regWrData[sync_ctrl_pkg::CW0_DIV_SYNC_EN];
               dualMode_q <= regWrData[sync_ctrl_pkg::CW0_DUAL_MODE];
               fifoOffset_q <= regWrData[sync_ctrl_pkg::CW0_OFFSET_LSB +: 3];
            end
            sync_ctrl_pkg::OFS_ALARM_MASK_WORD: begin
               mask_q <= regWrData[sync_ctrl_pkg::STAT_W-1:0];
            end
            sync_ctrl_pkg::OFS_MULTIPLIER_CONTROL_WORD: begin
               multEn_q <= regWrData[sync_ctrl_pkg::MCW_MULT_EN];
               loopSyncEn_q <= regWrData[sync_ctrl_pkg::MCW_LOOP_SYNC_EN];
               fbRatio_q <= regWrData[sync_ctrl_pkg::MCW_FB_RATIO_LSB +: 8];
            end
            sync_ctrl_pkg::OFS_SYNC_SELECT_WORD: begin
               divSrc_q <= regWrData[sync_ctrl_pkg::SSW_DIV_SRC_LSB +: 2];
               singleSrcSync_q <= regWrData[sync_ctrl_pkg::SSW_SINGLE_SRC];
            end
            default: begin
            end
         endcase
      end
   end

   // register reads, data valid only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (reset || !regRead) begin
         rdData_q <= '0;
      end else begin
         case (regAddr)
            sync_ctrl_pkg::OFS_CONTROL_WORD_ZERO:
               rdData_q <= {25'h0, fifoOffset_q, 2'h0, dualMode_q, divSyncEn_q};
            sync_ctrl_pkg::OFS_ALARM_STATUS_WORD:
               rdData_q <= {25'h0, status_q};
            sync_ctrl_pkg::OFS_ALARM_MASK_WORD:
               rdData_q <= {25'h0, mask_q};
            sync_ctrl_pkg::OFS_MULTIPLIER_CONTROL_WORD:
               rdData_q <= {16'h0, fbRatio_q, 6'h0, loopSyncEn_q, multEn_q};
            sync_ctrl_pkg::OFS_SYNC_SELECT_WORD:
               rdData_q <= {27'h0, singleSrcSync_q, 2'h0, divSrc_q};
            sync_ctrl_pkg::OFS_POINTER_STATE_WORD:
               rdData_q <= {8'h0, fbCnt_q, 4'h0, divCnt_q, 1'b0, rdPtr_q, 1'b0, wrPtr_q};
            default:
               rdData_q <= '0;
         endcase
      end
   end

   assign regRdData = rdData_q;
   assign writePtrReset = wrReset_q;
   assign readPtrReset = rdReset_q;
   assign dividerReset = divReset_q;
   assign loopDividerReset = loopReset_q;
   assign internalStrobe = intStrobe_q;
   assign dividedClkEn = divEn_q;
   assign writePtr = wrPtr_q;
   assign readPtr = rdPtr_q;
   assign alarmPin = alarmPin_q;
   assign irq = irq_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence s_single_write;
      !dualMode_q && wrEvent;
   endsequence
   sequence s_read_follows;
      ##3 rdReset_q && rdPtr_q == 3'h0;
   endsequence

   a_dual_read_output_strobe: assert property (
      dualMode_q && !multEn_q && ostrEv |=> rdReset_q && rdPtr_q == 3'h0)
      else $error("dual mode read reset missed output strobe");
   a_strobe_capture: assert property (
      ostrEv |-> $past(outputStrobe, 3) && $past(outputStrobe, 4))
      else $error("output strobe event without pin high");
   a_alarm_report: assert property (
      alarmNow[0] |=> status_q[sync_ctrl_pkg::ST_COLLISION] && alarmPin_q)
      else $error("collision alarm not reported");
   a_internal_strobe: assert property (
      dualMode_q && multEn_q && intStrobe_q |=> rdReset_q)
      else $error("internal strobe did not reset read pointer");
   a_loop_reset: assert property (
      loopEvent |=> fbCnt_q == 8'h00 && loopReset_q && !intStrobe_q)
      else $error("feedback divider not reset by sync edge");
   a_single_write: assert property (
      !dualMode_q && singleSrcSync_q && syncEv |=> wrReset_q && wrPtr_q == $past(fifoOffset_q))
      else $error("single mode write reset missed sync edge");
   a_single_handoff: assert property (
      s_single_write |-> s_read_follows)
      else $error("single mode read reset not two stages late");
   a_single_no_strobe: assert property (
      !dualMode_q && !handoff_q[1] |=> !rdReset_q)
      else $error("single mode read reset from wrong source");
   a_strobe_period: assert property (
      intStrobe_q && fbRatio_q >= 8'h02 && !loopEvent |=> !intStrobe_q)
      else $error("internal strobe longer than one cycle");
   a_edge_pulse: assert property (
      syncEv |=> !syncEv ##1 !syncEv)
      else $error("sync edge gave more than one pulse");
   a_divider_sync: assert property (
      divEvent |=> divReset_q && divCnt_q == 4'h0)
      else $error("divider not reset by sync event");
endmodule

// ===== tb/clock_distributor_model.sv
/*
 * Far-side model: the clock distributor and sync source driving the strobe and sync pins.
 * Assumes core_clk is the conversion clock that the distributor itself generates.
 */
`timescale 1ns/1ps
module clock_distributor_model (
   // clock
   input wire logic core_clk,
   // pins
   output logic outputStrobe,
   output logic inputStrobe,
   output logic syncIn
);
   initial begin
      outputStrobe = 1'b0;
      inputStrobe = 1'b0;
      syncIn = 1'b0;
   end
   // one rising edge per call, held for hold cycles, then back low
   task automatic fire(input int sel, input int hold);
      fork
         begin
            #12;
            // strobe moves at a fixed phase behind the conversion clock
            if (sel == 0) outputStrobe = 1'b1;
            if (sel == 1) inputStrobe = 1'b1;
            if (sel == 2) syncIn = 1'b1;
            repeat (hold) @(posedge core_clk);
            #12;
            outputStrobe = 1'b0;
            inputStrobe = 1'b0;
            syncIn = 1'b0;
         end
      join_none
   endtask
endmodule

// ===== tb/test_multi_device_sync_control.sv
/*
 * Self-checking bench for the multi-device sync control block.
 * Assumes the block's own assertions run beside it and the pin model drives all three pins.
 */
`timescale 1ns/1ps
module test_multi_device_sync_control;
   logic core_clk;
   logic reset;
   logic [7:0] regAddr;
   logic [31:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [31:0] regRdData;
   logic outputStrobe, inputStrobe, syncIn;
   logic writeTick, readTick;
   logic writePtrReset, readPtrReset, dividerReset, loopDividerReset;
   logic internalStrobe, dividedClkEn, alarmPin, irq;
   logic [2:0] writePtr, readPtr;
   int errCount = 0;
   int cmpCount = 0;
   int first[6], second[6], cnt[6];
   logic [31:0] rd;

   multi_device_sync_control multi_device_sync_control_i (
      .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .outputStrobe(outputStrobe), .inputStrobe(inputStrobe), .syncIn(syncIn),
      .writeTick(writeTick), .readTick(readTick), .writePtrReset(writePtrReset),
      .readPtrReset(readPtrReset), .dividerReset(dividerReset),
      .loopDividerReset(loopDividerReset), .internalStrobe(internalStrobe),
      .dividedClkEn(dividedClkEn), .writePtr(writePtr), .readPtr(readPtr),
      .alarmPin(alarmPin), .irq(irq));

   clock_distributor_model clock_distributor_model_i (
      .core_clk(core_clk), .outputStrobe(outputStrobe), .inputStrobe(inputStrobe),
      .syncIn(syncIn));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask

   // counts pulses of the six reset, strobe and enable outputs over n edges, noting the first two
   task automatic watch(input int n);
      logic [5:0] pv;
      for (int k = 0; k < 6; k++) begin
         first[k] = 0;
         second[k] = 0;
         cnt[k] = 0;
      end
      for (int i = 1; i <= n; i++) begin
         @(posedge core_clk);
         #1;
         pv = {dividedClkEn, internalStrobe, loopDividerReset, dividerReset, readPtrReset,
               writePtrReset};
         for (int k = 0; k < 6; k++) begin
            if (pv[k] === 1'b1) begin
               cnt[k]++;
               if (cnt[k] == 1) first[k] = i;
               if (cnt[k] == 2) second[k] = i;
            end
         end
      end
   endtask

   task automatic t_reset_values();
      reg_read(8'h00, rd);
      check(rd, 32'h41);
      reg_read(8'h04, rd);
      check(rd, 32'h0);
      reg_read(8'h08, rd);
      check(rd, 32'h0);
      reg_read(8'h0c, rd);
      check(rd, 32'h400);
      reg_read(8'h10, rd);
      check(rd, 32'h0);
      reg_read(8'h20, rd);
      check(rd, 32'h0);
      watch(16);
      check(cnt[4], 0);
      // free-running divider gives one enable pulse every eight cycles
      check(cnt[5], 2);
      check(second[5] - first[5], 8);
   endtask

   task automatic t_dual_strobe();
      reg_write(8'h10, 32'h0);
      reg_write(8'h00, 32'h43);
      clock_distributor_model_i.fire(1, 3);
      watch(12);
      check(first[0], 5);
      check(writePtr, 3'h4);
      // a long strobe must still give a single reset
      clock_distributor_model_i.fire(0, 10);
      watch(16);
      check(cnt[1], 1);
      check(first[1], 5);
      check(first[2], 5);
      check(cnt[2], 1);
      // the divider restarts from the sync event
      check(second[5] - first[2], 8);
      check(readPtr, 3'h0);
      reg_read(8'h14, rd);
      check(rd & 32'h77, 32'h04);
   endtask

   task automatic t_div_disable();
      reg_write(8'h00, 32'h42);
      clock_distributor_model_i.fire(0, 3);
      watch(12);
      check(cnt[1], 1);
      check(cnt[2], 0);
   endtask

   task automatic t_interrupt();
      reg_read(8'h04, rd);
      reg_read(8'h04, rd);
      check(rd, 32'h0);
      check(irq, 1'b0);
      reg_write(8'h08, 32'h08);
      clock_distributor_model_i.fire(1, 3);
      watch(12);
      check(irq, 1'b1);
      reg_read(8'h04, rd);
      check(rd & 32'h78, 32'h08);
      @(posedge core_clk);
      #1;
      check(irq, 1'b0);
   endtask

   task automatic t_collision();
      @(posedge core_clk);
      readTick <= 1'b1;
      repeat (4) @(posedge core_clk);
      readTick <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check(readPtr, writePtr);
      check(alarmPin, 1'b1);
      reg_read(8'h04, rd);
      check(rd & 32'h1, 32'h1);
   endtask

   task automatic t_loop_sync();
      reg_write(8'h0c, 32'h403);
      clock_distributor_model_i.fire(2, 3);
      watch(24);
      check(cnt[3], 1);
      check(first[3], 5);
      // the loop reset restarts the feedback count, so the next strobe is a full ratio later
      check(second[4] - first[3], 4);
      reg_read(8'h04, rd);
      check(rd & 32'h20, 32'h20);
      reg_write(8'h0c, 32'h401);
      clock_distributor_model_i.fire(2, 3);
      watch(12);
      check(cnt[3], 0);
      check(second[4] - first[4], 4);
      check(cnt[4] > 0, 1'b1);
   endtask

   task automatic t_single();
      reg_write(8'h00, 32'h41);
      for (int s = 0; s < 2; s++) begin
         // divider source follows the same pin: sync first, input strobe second
         reg_write(8'h10, s == 0 ? 32'h12 : 32'h01);
         clock_distributor_model_i.fire(s == 0 ? 2 : 1, 3);
         watch(14);
         check(first[0], 5);
         check(first[1], 7);
         check(cnt[2], 1);
      end
      clock_distributor_model_i.fire(0, 3);
      watch(14);
      check(cnt[1], 0);
      check(cnt[0], 0);
      check(cnt[2], 0);
   endtask

   initial begin
      reset = 1'b1;
      regAddr = 8'h0;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      writeTick = 1'b0;
      readTick = 1'b0;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      t_reset_values();
      t_dual_strobe();
      t_div_disable();
      t_interrupt();
      t_collision();
      t_loop_sync();
      t_single();
      @(posedge core_clk);
      writeTick <= 1'b1;
      @(posedge core_clk);
      writeTick <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      // one write advance from the loaded offset
      check(writePtr, 3'h5);
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      errCount++;
      finish_test();
   end
endmodule
